// ---- verilog/operand_field_decoder.sv ----
// Operand field decoder and executer for the 8-bit RISC core
//
// Functional notes
// - Full register operands reach R0-R31; limited operands reach R0-R15.
// - Indexed operand picks one of four index registers and four modes.
// - Mode 00 post-dec, 01 none, 10 post-inc, 11 pre-inc; lr 00..11 W..Z.
// - Interrupt enable control is 2 bits full form, 1 bit limited form.
// - One bit chooses if bank selects and ALU flags are saved/restored.
// - Two independent bits pick main or alternate half of banks A and B.
// - Stack push stores PC, interrupt enable, flags and banks as one entry.
// - Each instruction takes a fixed cycle count by variant and condition.
// - Wait count 00 adds no cycles beyond the listed count.
// - Add-immediate adds to a limited register, writes back, sets NZCV.
// - The immediate is eight bits and the sum replaces the register.
`include "opdec_consts.svh"
`timescale 1ns/1ns
module operand_field_decoder
    import opdec_pkg::*;
#(
    parameter int DW = 8,
    parameter int AW = 16
) (
    input  wire logic         i_clock,
    input  wire logic         i_resetn,
    input  wire logic [7:0]   i_reg_addr,
    input  wire logic [31:0]  i_reg_wdata,
    input  wire logic         i_reg_write,
    input  wire logic         i_reg_read,
    output logic      [31:0]  o_reg_rdata,
    input  wire logic         i_instr_valid,
    input  op_kind_e          i_op_kind,
    input  wire logic [15:0]  i_instr,
    input  wire logic         i_cond_met,
    input  wire logic [AW-1:0] i_pc,
    input  stack_entry_s      i_stack_top,
    output logic              o_instr_ready,
    output logic              o_instr_done,
    output logic              o_stack_push,
    output stack_entry_s      o_stack_entry,
    output logic              o_pc_load,
    output logic      [AW-1:0] o_pc_value,
    output logic              o_mem_write,
    output mem_wr_s           o_mem_wr
);
    typedef enum logic {ST_IDLE, ST_BUSY} run_state_e;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Physical slot of a register number under the bank selection
    function automatic logic [5:0] phys_idx(input logic [4:0] r,
                                            input logic       ba,
                                            input logic       bb);
        logic [5:0] idx;
        logic [4:0] a_first;
        a_first = `OPD_BANK_A_FIRST;
        idx = {1'b0, r};
        if (bb && r[4:2] == 3'b000) begin
            idx = `OPD_ALT_B_BASE + {4'b0, r[1:0]};
        end else if (ba && r[4:2] == a_first[4:2]) begin
            idx = `OPD_ALT_A_BASE + {4'b0, r[1:0]};
        end
        return idx;
    endfunction

    // Listed cycle count of one instruction
    function automatic logic [2:0] base_tstates(input op_kind_e op,
                                                input logic     cond);
        logic [2:0] t;
        t = `OPD_T_ADD_IMM;
        unique case (op)
            OP_ADD_IMM:  t = `OPD_T_ADD_IMM;
            OP_ADDA_REG: t = `OPD_T_ADDA_REG;
            OP_ADDA_IDX: t = `OPD_T_ADDA_IDX;
            OP_BANK_SEL: t = `OPD_T_BANK_SEL;
            OP_CALL:     t = `OPD_T_CALL;
            OP_RETURN:   t = `OPD_T_RETURN;
            OP_JCC:      t = cond ? `OPD_T_JCC_TAKEN : `OPD_T_JCC_MISS;
            OP_GIE_SET:  t = `OPD_T_GIE_SET;
            default:     t = `OPD_T_ADD_IMM;
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [DW-1:0]  regs_ff [0:`OPD_NUM_PHYS-1];
    logic [AW-1:0]  index_ff [0:3];
    alu_flags_s     flags_ff;
    logic           gie_ff;
    logic           ba_ff;
    logic           bb_ff;
    logic [1:0]     wait_ff;
    logic           clk_sel_ff;
    run_state_e     state_ff;
    logic [3:0]     cnt_ff;
    logic [31:0]    rdata_ff;
    logic           push_ff;
    stack_entry_s   entry_ff;
    logic           pc_load_ff;
    logic [AW-1:0]  pc_value_ff;
    logic           mem_write_ff;
    mem_wr_s        mem_wr_ff;

    // ------------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------------
    wire            take      = i_instr_valid && (state_ff == ST_IDLE);
    wire [7:0]      imm       = i_instr[`OPD_IMM_LSB +: 8];
    wire [4:0]      lim_reg   = {1'b0, i_instr[`OPD_LREG_LSB +: 4]};
    wire [4:0]      rd_reg    = i_instr[`OPD_RD_LSB +: 5];
    wire [4:0]      rs_reg    = i_instr[`OPD_RS_LSB +: 5];
    index_mode_e    idx_mode;
    index_sel_e     idx_sel;
    assign idx_mode = index_mode_e'(i_instr[`OPD_MODE_LSB +: 2]);
    assign idx_sel  = index_sel_e'(i_instr[`OPD_IREG_LSB +: 2]);
    wire [1:0]      g_full    = i_instr[`OPD_GFULL_LSB +: 2];
    wire            g_lim     = i_instr[`OPD_GLIM_BIT];
    wire            rf_call   = i_instr[`OPD_RF_BIT];
    wire            rf_ret    = i_instr[`OPD_RET_RF_BIT];
    wire            new_ba    = i_instr[`OPD_EXX_BA_BIT];
    wire            new_bb    = i_instr[`OPD_EXX_BB_BIT];

    wire [5:0]      lim_phys  = phys_idx(lim_reg, ba_ff, bb_ff);
    wire [5:0]      rd_phys   = phys_idx(rd_reg, ba_ff, bb_ff);
    wire [5:0]      rs_phys   = phys_idx(rs_reg, ba_ff, bb_ff);
    wire [5:0]      acc_phys  = phys_idx(`OPD_ACC_REG, ba_ff, bb_ff);
    wire            is_add    = (i_op_kind == OP_ADD_IMM);
    wire [DW-1:0]   add_a     = is_add ? regs_ff[lim_phys]
                                       : regs_ff[rs_phys];
    wire [DW-1:0]   add_b     = is_add ? imm : regs_ff[acc_phys];
    wire [DW-1:0]   sum;
    alu_flags_s     sum_flags;
    wire [AW-1:0]   idx_value = index_ff[idx_sel];
    wire [AW-1:0]   idx_addr;
    wire [AW-1:0]   idx_next;

    // Total cycles: listed count plus programmed wait cycles
    wire [3:0]      total_cyc = {1'b0, base_tstates(i_op_kind, i_cond_met)}
                                + {2'b00, wait_ff};

    wire            wr_reg    = take && (is_add ||
                                (i_op_kind == OP_ADDA_REG));
    wire [5:0]      wr_phys   = is_add ? lim_phys : rd_phys;
    wire            upd_flags = take && (is_add ||
                                (i_op_kind == OP_ADDA_REG) ||
                                (i_op_kind == OP_ADDA_IDX));
    wire            upd_index = take && (i_op_kind == OP_ADDA_IDX);
    wire            do_ret    = take && (i_op_kind == OP_RETURN);

    add_flags_unit #(.W(DW)) u_add (
        .i_a     (add_a),
        .i_b     (add_b),
        .o_sum   (sum),
        .o_flags (sum_flags)
    );

    index_addr_unit #(.AW(AW)) u_index (
        .i_value (idx_value),
        .i_mode  (idx_mode),
        .o_addr  (idx_addr),
        .o_next  (idx_next)
    );

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    wire            sw_ctrl   = i_reg_write && (i_reg_addr == `OPD_CTRL_OFS);
    wire            sw_index  = i_reg_write && (i_reg_addr[7:4] == 4'h1) &&
                                (i_reg_addr[1:0] == 2'b00);
    wire [1:0]      sw_isel   = i_reg_addr[3:2];
    wire [31:0]     ctrl_view = {29'h0, clk_sel_ff, wait_ff};
    wire [31:0]     stat_view = {24'h0, (state_ff == ST_BUSY), bb_ff,
                                 ba_ff, gie_ff, flags_ff};
    wire [31:0]     read_mux  =
        (i_reg_addr == `OPD_CTRL_OFS)    ? ctrl_view :
        (i_reg_addr == `OPD_STATUS_OFS)  ? stat_view :
        (i_reg_addr == `OPD_INDEX_W_OFS) ? {16'h0, index_ff[0]} :
        (i_reg_addr == `OPD_INDEX_X_OFS) ? {16'h0, index_ff[1]} :
        (i_reg_addr == `OPD_INDEX_Y_OFS) ? {16'h0, index_ff[2]} :
        (i_reg_addr == `OPD_INDEX_Z_OFS) ? {16'h0, index_ff[3]} :
        32'h0000_0000;

    assign o_reg_rdata   = rdata_ff;
    assign o_instr_ready = (state_ff == ST_IDLE);
    assign o_instr_done  = (state_ff == ST_BUSY) && (cnt_ff == 4'h1);
    assign o_stack_push  = push_ff;
    assign o_stack_entry = entry_ff;
    assign o_pc_load     = pc_load_ff;
    assign o_pc_value    = pc_value_ff;
    assign o_mem_write   = mem_write_ff;
    assign o_mem_wr      = mem_wr_ff;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_ff    <= 2'h0;
            clk_sel_ff <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            rdata_ff <= i_reg_read ? read_mux : 32'h0000_0000;
            if (sw_ctrl) begin
                wait_ff    <= i_reg_wdata[`OPD_CTRL_WAIT_LSB +: 2];
                clk_sel_ff <= i_reg_wdata[`OPD_CTRL_CLKSEL_BIT];
            end
        end
    end

    // Software write to an index register wins over the pointer update
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < 4; i++) begin
                index_ff[i] <= '0;
            end
        end else if (sw_index) begin
            index_ff[sw_isel] <= i_reg_wdata[AW-1:0];
        end else if (upd_index) begin
            index_ff[idx_sel] <= idx_next;
        end
    end

    // ------------------------------------------------------------------
    // Register file and processor status
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < `OPD_NUM_PHYS; i++) begin
                regs_ff[i] <= '0;
            end
        end else if (wr_reg) begin
            regs_ff[wr_phys] <= sum;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            flags_ff <= '0;
            gie_ff   <= 1'b0;
            ba_ff    <= 1'b0;
            bb_ff    <= 1'b0;
        end else if (upd_flags) begin
            flags_ff <= sum_flags;
        end else if (take && i_op_kind == OP_BANK_SEL) begin
            ba_ff <= new_ba;
            bb_ff <= new_bb;
        end else if (take && i_op_kind == OP_GIE_SET && g_full[1]) begin
            gie_ff <= g_full[0];
        end else if (do_ret) begin
            if (g_lim) begin
                gie_ff <= i_stack_top.global_irq_enable;
            end
            if (rf_ret) begin
                flags_ff <= i_stack_top.flags;
                ba_ff    <= i_stack_top.bank_a_select;
                bb_ff    <= i_stack_top.bank_b_select;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs toward stack, program counter and data memory
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            push_ff      <= 1'b0;
            entry_ff     <= '0;
            pc_load_ff   <= 1'b0;
            pc_value_ff  <= '0;
            mem_write_ff <= 1'b0;
            mem_wr_ff    <= '0;
        end else begin
            push_ff      <= take && (i_op_kind == OP_CALL);
            pc_load_ff   <= do_ret;
            mem_write_ff <= upd_index;
            if (take && i_op_kind == OP_CALL) begin
                entry_ff <= {i_pc, gie_ff, flags_ff, ba_ff, bb_ff};
                if (!rf_call) begin
                    entry_ff.flags         <= '0;
                    entry_ff.bank_a_select <= 1'b0;
                    entry_ff.bank_b_select <= 1'b0;
                end
            end
            if (do_ret) begin
                pc_value_ff <= i_stack_top.pc;
            end
            if (upd_index) begin
                mem_wr_ff <= {idx_addr, sum};
            end
        end
    end

    // ------------------------------------------------------------------
    // Cycle accounting
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 4'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (take) begin
                        state_ff <= ST_BUSY;
                        cnt_ff   <= total_cyc - 4'h1;
                    end
                end
                ST_BUSY: begin
                    cnt_ff <= cnt_ff - 4'h1;
                    if (cnt_ff == 4'h1) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    add_cycles_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        take && is_add && wait_ff == 2'h0 |-> ##1 o_instr_done)
        else $error("add without waits did not take two cycles");

    index_cycles_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        take && i_op_kind == OP_ADDA_IDX && wait_ff == 2'h0
        |-> ##1 !o_instr_done ##1 o_instr_done)
        else $error("indexed add did not take three cycles");

    wait_extend_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        take && is_add && wait_ff == 2'h3
        |-> ##1 (!o_instr_done)[*3] ##1 o_instr_done ##1 o_instr_ready)
        else $error("wait cycles not added to add");

    push_entry_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        take && i_op_kind == OP_CALL |=> o_stack_push &&
        o_stack_entry.pc == $past(i_pc) &&
        o_stack_entry.global_irq_enable == $past(gie_ff))
        else $error("stack entry does not hold pc and enable");

    pre_inc_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        upd_index && idx_mode == MODE_PRE_INC && !sw_index
        |=> o_mem_write && o_mem_wr.addr == $past(idx_value) + 16'h1 &&
        index_ff[$past(idx_sel)] == o_mem_wr.addr)
        else $error("pre-increment address wrong");

    add_write_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        take && is_add |=> regs_ff[$past(lim_phys)] ==
        $past(regs_ff[lim_phys]) + $past(imm))
        else $error("add immediate result not written back");

    bank_sel_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        take && i_op_kind == OP_BANK_SEL
        |=> ba_ff == $past(new_ba) && bb_ff == $past(new_bb))
        else $error("bank selection not taken");

    ret_keep_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        do_ret && !rf_ret |=> flags_ff == $past(flags_ff) &&
        ba_ff == $past(ba_ff) && bb_ff == $past(bb_ff))
        else $error("return without restore changed status");

    gie_set_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        take && i_op_kind == OP_GIE_SET && g_full == 2'h3 |=> gie_ff)
        else $error("interrupt enable not set");

    acc_bank_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        bb_ff |-> acc_phys == `OPD_ALT_B_BASE)
        else $error("alternate accumulator not used");

endmodule // operand_field_decoder

// ---- verilog/opdec_consts.svh ----
// Offsets, field positions, reset values and cycle counts of the decoder
`ifndef OPDEC_CONSTS_SVH
`define OPDEC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OPD_CTRL_OFS        8'h00
`define OPD_STATUS_OFS      8'h04
`define OPD_INDEX_W_OFS     8'h10
`define OPD_INDEX_X_OFS     8'h14
`define OPD_INDEX_Y_OFS     8'h18
`define OPD_INDEX_Z_OFS     8'h1c

// ----------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------
`define OPD_CTRL_WAIT_LSB   0
`define OPD_CTRL_CLKSEL_BIT 2
`define OPD_CTRL_RESET      32'h0000_0000
`define OPD_ST_FLAGS_LSB    0
`define OPD_ST_GIE_BIT      4
`define OPD_ST_BA_BIT       5
`define OPD_ST_BB_BIT       6
`define OPD_ST_BUSY_BIT     7

// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define OPD_IMM_LSB         4
`define OPD_LREG_LSB        0
`define OPD_RD_LSB          5
`define OPD_RS_LSB          0
`define OPD_MODE_LSB        7
`define OPD_IREG_LSB        5
`define OPD_EXX_BA_BIT      1
`define OPD_EXX_BB_BIT      0
`define OPD_GFULL_LSB       9
`define OPD_RF_BIT          8
`define OPD_GLIM_BIT        1
`define OPD_RET_RF_BIT      0

// ----------------------------------------------------------------------
// Register file layout
// ----------------------------------------------------------------------
`define OPD_NUM_GPR         32
`define OPD_NUM_LIMITED     16
`define OPD_NUM_PHYS        40
`define OPD_ALT_B_BASE      6'd32
`define OPD_ALT_A_BASE      6'd36
`define OPD_BANK_A_FIRST    5'd8
`define OPD_ACC_REG         5'd0

// ----------------------------------------------------------------------
// Cycle counts (T-states) and clock
// ----------------------------------------------------------------------
`define OPD_CLK_PERIOD_NS   4
`define OPD_T_ADD_IMM       3'd2
`define OPD_T_ADDA_REG      3'd2
`define OPD_T_ADDA_IDX      3'd3
`define OPD_T_BANK_SEL      3'd2
`define OPD_T_CALL          3'd2
`define OPD_T_RETURN        3'd2
`define OPD_T_JCC_MISS      3'd2
`define OPD_T_JCC_TAKEN     3'd3
`define OPD_T_GIE_SET       3'd2

`endif

// ---- verilog/opdec_pkg.sv ----
// Types shared by the operand field decoder modules
package opdec_pkg;

    typedef enum logic [3:0] {
        OP_ADD_IMM,
        OP_ADDA_REG,
        OP_ADDA_IDX,
        OP_BANK_SEL,
        OP_CALL,
        OP_RETURN,
        OP_JCC,
        OP_GIE_SET
    } op_kind_e;

    typedef enum logic [1:0] {
        MODE_POST_DEC,
        MODE_NO_CHANGE,
        MODE_POST_INC,
        MODE_PRE_INC
    } index_mode_e;

    typedef enum logic [1:0] {
        INDEX_REG_W,
        INDEX_REG_X,
        INDEX_REG_Y,
        INDEX_REG_Z
    } index_sel_e;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } alu_flags_s;

    typedef struct packed {
        logic [15:0] pc;
        logic        global_irq_enable;
        alu_flags_s  flags;
        logic        bank_a_select;
        logic        bank_b_select;
    } stack_entry_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_wr_s;

endpackage

// ---- verilog/add_flags_unit.sv ----
// Adder with negative, zero, carry and overflow flags
`timescale 1ns/1ns
module add_flags_unit
    import opdec_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic [W-1:0] i_a,
    input  wire logic [W-1:0] i_b,
    output logic      [W-1:0] o_sum,
    output alu_flags_s        o_flags
);
    wire [W:0] full_sum = {1'b0, i_a} + {1'b0, i_b};

    assign o_sum     = full_sum[W-1:0];
    assign o_flags.n = full_sum[W-1];
    assign o_flags.z = (full_sum[W-1:0] == '0);
    assign o_flags.c = full_sum[W];
    assign o_flags.v = (i_a[W-1] == i_b[W-1]) &&
                       (full_sum[W-1] != i_a[W-1]);
endmodule // add_flags_unit

// ---- verilog/index_addr_unit.sv ----
// Effective address and pointer update for the four index modes
`timescale 1ns/1ns
module index_addr_unit
    import opdec_pkg::*;
#(
    parameter int AW = 16
) (
    input  wire logic [AW-1:0] i_value,
    input  index_mode_e        i_mode,
    output logic      [AW-1:0] o_addr,
    output logic      [AW-1:0] o_next
);
    wire [AW-1:0] plus_one  = i_value + AW'(1);
    wire [AW-1:0] minus_one = i_value - AW'(1);

    // Pre-increment uses the bumped pointer, the others the old one
    assign o_addr = (i_mode == MODE_PRE_INC) ? plus_one : i_value;
    assign o_next = (i_mode == MODE_POST_DEC)  ? minus_one :
                    (i_mode == MODE_NO_CHANGE) ? i_value   :
                    plus_one;
endmodule // index_addr_unit

// ---- bench/operand_field_decoder_tb.sv ----
// Self-checking testbench for the operand field decoder
`timescale 1ns/1ns
`include "opdec_consts.svh"
module operand_field_decoder_tb
    import opdec_pkg::*;
();
    logic         i_clock, i_resetn, i_reg_write, i_reg_read;
    logic         i_instr_valid, i_cond_met;
    logic [7:0]   i_reg_addr;
    logic [31:0]  i_reg_wdata, o_reg_rdata, d;
    op_kind_e     i_op_kind;
    logic [15:0]  i_instr, i_pc, o_pc_value, c_pcv;
    stack_entry_s i_stack_top, o_stack_entry, c_ent;
    mem_wr_s      o_mem_wr, c_mwr;
    logic         o_instr_ready, o_instr_done, o_stack_push, o_pc_load;
    logic         o_mem_write, c_push, c_load, c_mw;
    int           mismatches, n_tests, t;

    operand_field_decoder #(.DW(8), .AW(16)) uut (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
        .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
        .i_instr_valid(i_instr_valid), .i_op_kind(i_op_kind),
        .i_instr(i_instr), .i_cond_met(i_cond_met), .i_pc(i_pc),
        .i_stack_top(i_stack_top), .o_instr_ready(o_instr_ready),
        .o_instr_done(o_instr_done), .o_stack_push(o_stack_push),
        .o_stack_entry(o_stack_entry), .o_pc_load(o_pc_load),
        .o_pc_value(o_pc_value), .o_mem_write(o_mem_write),
        .o_mem_wr(o_mem_wr));

    // ------------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_reg_addr  <= a;
        i_reg_wdata <= v;
        i_reg_write <= 1'b1;
        @(posedge i_clock);
        i_reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_clock);
        i_reg_read <= 1'b0;
        #1 v = o_reg_rdata;
    endtask
    task automatic st(input logic [31:0] e);
        rd(`OPD_STATUS_OFS, d);
        chk("status", e, d);
    endtask
    // Issues one instruction, keeps the first-cycle pulses, counts cycles
    task automatic ins(input op_kind_e k, input logic [15:0] w,
                       input logic c);
        @(posedge i_clock);
        i_op_kind     <= k;
        i_instr       <= w;
        i_cond_met    <= c;
        i_instr_valid <= 1'b1;
        @(posedge i_clock);
        i_instr_valid <= 1'b0;
        #1;
        {c_push, c_ent, c_load, c_pcv} = {o_stack_push, o_stack_entry,
                                          o_pc_load, o_pc_value};
        {c_mw, c_mwr} = {o_mem_write, o_mem_wr};
        t = 2;
        while (o_instr_done !== 1'b1 && t < 20) begin
            @(posedge i_clock);
            #1;
            t++;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd(`OPD_CTRL_OFS, d);
        chk("ctrl", 32'h0, d);
        st(32'h0);
        wr(`OPD_CTRL_OFS, 32'h7);
        rd(`OPD_CTRL_OFS, d);
        chk("ctrl", 32'h7, d);
        wr(`OPD_STATUS_OFS, 32'hff);
        st(32'h0);
        wr(8'h08, 32'hff);
        rd(8'h08, d);
        chk("unmapped", 32'h0, d);
        wr(`OPD_CTRL_OFS, 32'h0);
    endtask
    task automatic t_add;
        ins(OP_ADD_IMM, 16'h0800, 1'b0);
        chk("cycles", 2, t);
        chk("ready", 32'h0, {31'h0, o_instr_ready});
        st(32'h08);
        ins(OP_ADD_IMM, 16'h0800, 1'b0);
        st(32'h07);
        ins(OP_ADD_IMM, 16'h0030, 1'b0);
        ins(OP_ADD_IMM, 16'h005f, 1'b0);
        ins(OP_ADDA_REG, {6'h0, 5'd31, 5'd15}, 1'b0);
        chk("cycles", 2, t);
    endtask
    task automatic t_index;
        logic [15:0] p, a, n;
        for (int i = 0; i < 4; i++)
            wr(`OPD_INDEX_W_OFS + 8'(4 * i), 32'h1000 + 32'(i * 16));
        for (int i = 0; i < 4; i++) begin
            p = 16'h1000 + 16'(i * 16);
            a = (i == 3) ? p + 16'h1 : p;
            n = (i == 0) ? p - 16'h1 : (i == 1) ? p : p + 16'h1;
            ins(OP_ADDA_IDX, {7'h0, 2'(i), 2'(i), 5'd31}, 1'b0);
            chk("mem_wr", {8'h1, a, 8'h0b}, {7'h0, c_mw, c_mwr});
            chk("cycles", 3, t);
            rd(`OPD_INDEX_W_OFS + 8'(4 * i), d);
            chk("index", {16'h0, n}, d);
        end
    endtask
    task automatic t_bank;
        ins(OP_BANK_SEL, 16'h0001, 1'b0);
        st(32'h40);
        ins(OP_ADD_IMM, 16'h0200, 1'b0);
        ins(OP_ADDA_IDX, {7'h0, 2'b01, 2'b00, 5'd15}, 1'b0);
        chk("mem_wr", {8'h1, 16'h0fff, 8'h25}, {7'h0, c_mw, c_mwr});
        ins(OP_BANK_SEL, 16'h0002, 1'b0);
        st(32'h20);
        ins(OP_ADDA_IDX, {7'h0, 2'b01, 2'b00, 5'd15}, 1'b0);
        chk("mem_wr", {8'h1, 16'h0fff, 8'h08}, {7'h0, c_mw, c_mwr});
    endtask
    task automatic t_stack;
        for (int k = 0; k < 4; k++) begin
            ins(OP_GIE_SET, {5'h0, 2'(k + 3), 9'h0}, 1'b0);
            st(k == 3 ? 32'h20 : 32'h30);
        end
        ins(OP_CALL, 16'h0100, 1'b0);
        chk("push", {1'b1, 16'h1234, 1'b0, 4'h0, 2'b10}, {c_push, c_ent});
        ins(OP_RETURN, 16'h0003, 1'b0);
        chk("pc_load", {1'b1, 16'h4321}, {c_load, c_pcv});
        st(32'h5a);
        ins(OP_CALL, 16'h0000, 1'b0);
        chk("push", {1'b1, 16'h1234, 1'b1, 6'h0}, {c_push, c_ent});
        ins(OP_RETURN, 16'h0000, 1'b0);
        st(32'h5a);
    endtask
    task automatic t_timing;
        for (int w = 0; w < 4; w += 3) begin
            wr(`OPD_CTRL_OFS, 32'(w));
            ins(OP_ADD_IMM, 16'h0, 1'b0);
            chk("cycles", 32'(2 + w), t);
            ins(OP_JCC, 16'h0, 1'b0);
            chk("cycles", 32'(2 + w), t);
            ins(OP_JCC, 16'h0, 1'b1);
            chk("cycles", 32'(3 + w), t);
        end
        wr(`OPD_CTRL_OFS, 32'h0);
    endtask

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    initial begin
        {mismatches, n_tests} = '0;
        {i_resetn, i_reg_write, i_reg_read, i_instr_valid} = '0;
        {i_cond_met, i_reg_addr, i_reg_wdata, i_instr} = '0;
        i_op_kind = OP_ADD_IMM;
        i_pc = 16'h1234;
        i_stack_top = {16'h4321, 1'b1, 4'b1010, 1'b0, 1'b1};
        repeat (3) @(posedge i_clock);
        i_resetn <= 1'b1;
        t_regs;
        t_add;
        t_index;
        t_bank;
        t_stack;
        t_timing;
        tally_and_finish;
    end
    initial begin
        #20000;
        mismatches++;
        tally_and_finish;
    end
endmodule // operand_field_decoder_tb
